// file: inc/tcms_pkg.sv
// Package for the timer channel mode select block.
// Assumes one bus clock domain; no register bus, all bits are ports.
package tcms_pkg;

  // ******************************************************************
  // Mode encodings
  // ******************************************************************
  typedef enum logic [1:0] {
    TCMS_PRESET  = 2'h0,
    TCMS_CAPTURE = 2'h1,
    TCMS_CMP_UNB = 2'h3,
    TCMS_CMP_BUF = 2'h2
  } tcms_mode_t;

  // Edge/level field values
  localparam logic [1:0] TCMS_EL_NONE = 2'h0;
  localparam logic [1:0] TCMS_EL_RISE = 2'h1;
  localparam logic [1:0] TCMS_EL_FALL = 2'h2;
  localparam logic [1:0] TCMS_EL_BOTH = 2'h3;

  // Values after reset, and synchroniser depth
  localparam logic TCMS_RST_PIN = 1'h0;
  localparam logic TCMS_RST_FLAG = 1'h0;
  localparam int TCMS_SYNC_STAGES = 2;

endpackage

// file: tb/tcms_channel_test.sv
// Bench for tcms_channel; all inputs driven, pin from the model.
`timescale 1ns/10ps
module tcms_channel_test;
  import tcms_pkg::*;
  logic clk = 0, rst_n = 0, want = 0, channel_pin_in, channel_pin_out, channel_pin_oe;
  logic chan_mode_high_bit, chan_mode_low_bit, edge_level_high_bit, edge_level_low_bit;
  logic toggle_on_rollover, compare_match = 0, counter_overflow = 0, flag_clear = 0;
  logic channel_event_flag, xp;
  logic [15:0] counter_value = 16'h0, capture_value;
  tcms_mode_t chan_mode;
  int errors = 0, samples_checked = 0;
  always #5 clk = ~clk;
  tcms_pin_model i_pin (.*);
  tcms_channel i_dut (.*);
  task step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string s, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Mode bits change only while the counter is idle: no overflow, no match
  task cfg(input logic [4:0] v);
    {chan_mode_high_bit, chan_mode_low_bit, edge_level_high_bit, edge_level_low_bit,
      toggle_on_rollover} = v;
    step(1);
  endtask
  task pulse(input logic [2:0] v);
    {compare_match, counter_overflow, flag_clear} = v;
    step(1);
    {compare_match, counter_overflow, flag_clear} = 3'h0;
  endtask
  initial begin
    cfg(5'h00);
    step(1);
    rst_n = 1;
    chk("flag", 0, channel_event_flag);
    step(1);
    chk("preset", 1, channel_pin_out);
    chk("oe", 0, channel_pin_oe);
    for (int m = 1; m < 4; m++) begin
      for (int e = 1; e < 4; e++) begin
        cfg({m[1:0], 3'h0});
        xp = !m[0];
        cfg({m[1:0], e[1:0], 1'b0});
        chk("oe", 1, channel_pin_oe);
        chk("mode", m[1] ? 2 : 3, chan_mode);
        pulse(3'h4);
        chk("pin", e == 1 ? !xp : e == 3, channel_pin_out);
        chk("flag", 1, channel_event_flag);
        pulse(3'h1);
        chk("clear", 0, channel_event_flag);
      end
    end
    cfg(5'h0f);
    pulse(3'h6);
    chk("ovf wins", 0, channel_pin_out);
    pulse(3'h2);
    chk("ovf tog", 1, channel_pin_out);
    cfg(5'h0e);
    pulse(3'h2);
    chk("no tog", 1, channel_pin_out);
    for (int e = 1; e < 4; e++) begin
      counter_value = 16'h00a0 + 16'(e);
      cfg({2'b00, e[1:0], 1'b1});
      pulse(3'h3);
      chk("cap pin", 1, channel_pin_out);
      want = 1;
      step(6);
      chk("rise", e[0], channel_event_flag);
      if (e[0]) chk("cap", counter_value, capture_value);
      pulse(3'h1);
      want = 0;
      step(6);
      chk("fall", e[1], channel_event_flag);
    end
    end_of_test;
  end
  initial begin
    #5000;
    errors++;
    end_of_test;
  end
endmodule

// file: tb/tcms_monitor.sv
// Checker for tcms_channel, bound to its ports.
// Assumes one clock and rst_n asynchronous, active low.
`timescale 1ns/10ps
module tcms_monitor
  import tcms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Configuration and timer
  input wire logic chan_mode_high_bit,
  input wire logic chan_mode_low_bit,
  input wire logic edge_level_high_bit,
  input wire logic edge_level_low_bit,
  input wire logic toggle_on_rollover,
  input wire logic counter_overflow,
  input wire logic compare_match,
  input wire logic flag_clear,
  // Outputs
  input wire logic channel_pin_out,
  input wire logic channel_pin_oe,
  input wire logic channel_event_flag,
  input tcms_mode_t chan_mode
);
  wire [1:0] el = {edge_level_high_bit, edge_level_low_bit};
  wire oc = (chan_mode_high_bit | chan_mode_low_bit) && el != 2'h0;
  wire tg = oc && toggle_on_rollover && counter_overflow;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_oe_drive: assert property (channel_pin_oe == oc) else $error("oe wrong");
  a_mode_decode: assert property (chan_mode == (el == 2'h0 ? TCMS_PRESET :
    chan_mode_high_bit ? TCMS_CMP_BUF : chan_mode_low_bit ? TCMS_CMP_UNB : TCMS_CAPTURE))
    else $error("mode wrong");
  a_preset_level: assert property (el == 2'h0 |=>
    channel_pin_out == !$past(chan_mode_low_bit)) else $error("preset wrong");
  a_ovf_toggle: assert property (tg |=>
    channel_pin_out != $past(channel_pin_out)) else $error("no toggle");
  a_cmp_action: assert property (oc && compare_match && !tg |=>
    channel_pin_out == ($past(el) == 2'h1 ? !$past(channel_pin_out) : $past(el) == 2'h3))
    else $error("compare action wrong");
  a_capture_hold: assert property (!chan_mode_high_bit && !chan_mode_low_bit &&
    el != 2'h0 |=> $stable(channel_pin_out)) else $error("pin moved");
  a_cmp_flag: assert property (oc && compare_match |=> channel_event_flag)
    else $error("flag not set");
  a_flag_sticky: assert property (channel_event_flag && !flag_clear |=>
    channel_event_flag) else $error("flag lost");
  c_cmp: cover property (oc && compare_match);
  c_ovf_win: cover property (tg && compare_match);
  c_cap: cover property (chan_mode == TCMS_CAPTURE && $rose(channel_event_flag));
endmodule
bind tcms_channel tcms_monitor i_mon (.*);

// file: tb/tcms_pin_model.sv
// Outside source of the channel pin level.
// Assumes the bench sets the wanted level.
`timescale 1ns/10ps
module tcms_pin_model (
  // Clock and request
  input wire logic clk,
  input wire logic want,
  // Pin
  output logic channel_pin_in
);
  initial channel_pin_in = 1'h0;
  // Moves off the clock edge, unrelated to the timer
  always @(posedge clk) begin
    channel_pin_in <= #3 want;
  end
endmodule

// file: verilog/tcms_channel.sv
// One timer channel: mode decode, input capture, output compare, pin drive.
// Assumes the counter, its overflow strobe and the compare match come from
// the timer core on clk; the pin input is asynchronous.
`timescale 1ns/10ps

// How it works
// - In preset mode the low mode bit picks initial level: 1 low, 0 high.
// - Edge/level bits both clear leave the pin to the general I/O port.
// - Mode 00 captures on rising, falling or both edges per edge bits.
// - Mode 01 compares unbuffered: toggle, clear or set pin.
// - High mode bit set gives buffered compare with toggle, clear or set.
// - Edge bits select capture edges or the compare pin action by mode.
// - Reset clears pin level, event flag, capture value and the edge detector.
// - Toggle-on-rollover inverts an output compare pin at each overflow.
// - Toggle-on-rollover does nothing for an input capture channel.
// - Overflow toggle wins over a compare match in the same cycle.
module tcms_channel
  import tcms_pkg::*;
#(
  parameter int CNT_W = 16
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Channel configuration
  input wire logic chan_mode_high_bit,
  input wire logic chan_mode_low_bit,
  input wire logic edge_level_high_bit,
  input wire logic edge_level_low_bit,
  input wire logic toggle_on_rollover,
  // Timer core
  input wire logic [CNT_W-1:0] counter_value,
  input wire logic counter_overflow,
  input wire logic compare_match,
  // Event flag clear from software
  input wire logic flag_clear,
  // Channel pin
  input wire logic channel_pin_in,
  output logic channel_pin_out,
  output logic channel_pin_oe,
  // Status
  output logic channel_event_flag,
  output logic [CNT_W-1:0] capture_value,
  output tcms_mode_t chan_mode
);

  initial begin
    if (CNT_W < 1 || CNT_W > 32) begin
      $error("CNT_W out of range");
    end
  end

  // ******************************************************************
  // Mode decode
  // ******************************************************************
  wire logic [1:0] edge_sel = {edge_level_high_bit, edge_level_low_bit};
  wire logic pin_detached = (edge_sel == TCMS_EL_NONE);
  wire logic is_capture = !chan_mode_high_bit && !chan_mode_low_bit
                          && !pin_detached;
  wire logic is_compare = (chan_mode_high_bit || chan_mode_low_bit)
                          && !pin_detached;
  wire logic preset_level = !chan_mode_low_bit;

  assign chan_mode = pin_detached ? TCMS_PRESET :
                     chan_mode_high_bit ? TCMS_CMP_BUF :
                     chan_mode_low_bit ? TCMS_CMP_UNB : TCMS_CAPTURE;

  // ******************************************************************
  // Capture edge detection
  // ******************************************************************
  logic pin_sync;
  logic pin_prev_q;

  tcms_sync u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d_in(channel_pin_in),
    .d_out(pin_sync)
  );

  wire logic rise = pin_sync && !pin_prev_q;
  wire logic fall = !pin_sync && pin_prev_q;
  wire logic capture_hit = is_capture
                           && ((edge_level_low_bit && rise)
                           || (edge_level_high_bit && fall));

  // ******************************************************************
  // Compare and overflow pin action
  // ******************************************************************
  wire logic ovf_toggle = is_compare && toggle_on_rollover
                          && counter_overflow;
  wire logic cmp_act = is_compare && compare_match;
  logic pin_d;

  always_comb begin
    pin_d = channel_pin_out;
    if (pin_detached) begin
      pin_d = preset_level;
    end else if (ovf_toggle) begin
      pin_d = !channel_pin_out;
    end else if (cmp_act) begin
      unique case (edge_sel)
        TCMS_EL_RISE: pin_d = !channel_pin_out;
        TCMS_EL_FALL: pin_d = 1'h0;
        TCMS_EL_BOTH: pin_d = 1'h1;
        TCMS_EL_NONE: pin_d = channel_pin_out;
      endcase
    end
  end

  // Pin is driven only when a compare mode owns it
  assign channel_pin_oe = is_compare;

  // ******************************************************************
  // State
  // ******************************************************************
  logic flag_q;
  logic [CNT_W-1:0] cap_q;
  logic pin_q;

  wire logic event_set = capture_hit || cmp_act;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      // Config bits are held clear by their owner during reset
      pin_prev_q <= 1'h0;
      pin_q <= TCMS_RST_PIN;
      flag_q <= TCMS_RST_FLAG;
      cap_q <= '0;
    end else begin
      pin_prev_q <= pin_sync;
      pin_q <= pin_d;
      flag_q <= event_set || (flag_q && !flag_clear);
      if (capture_hit) begin
        cap_q <= counter_value;
      end
    end
  end

  assign channel_pin_out = pin_q;
  assign channel_event_flag = flag_q;
  assign capture_value = cap_q;

endmodule

// file: verilog/tcms_sync.sv
// Two flip-flop synchroniser for the channel pin input.
// Assumes the input is asynchronous to clk.
`timescale 1ns/10ps
module tcms_sync
  import tcms_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic d_in,
  output logic d_out
);

  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'h0;
      sync_q <= 1'h0;
    end else begin
      meta_q <= d_in;
      sync_q <= meta_q;
    end
  end

  assign d_out = sync_q;

endmodule
